// ===== bench/ldr_host_model.sv
// ldr_host_model.sv - two-wire bus master for the display driver slave
// assumes the bench resolves both lines with pull-ups from the pull outputs
`timescale 1ns/1ns
module ldr_host_model (
  // system
  input  wire logic mclk,
  // resolved bus levels
  input  wire logic scl,
  input  wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic      sclPull,
  output logic      sdaPull,
  // acknowledge report, strobe stands one mclk
  output logic      ackStrobe,
  output logic      ackSeen,
  output logic      hung
);
  // bus released at time zero
  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    ackStrobe = 1'b0;
    ackSeen = 1'b0;
    hung = 1'b0;
  end

  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // quarter of the 400 ns bus period; moves land just after an edge
  task automatic q();
    repeat (2) @(posedge mclk);
    #5;
  endtask

  // release the clock and wait out a stretch by the slave, bounded
  task automatic rise();
    int n;
    n = 0;
    sclPull = 1'b0;
    @(posedge mclk);
    while (scl !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 4000) hung = 1'b1;
    #5;
    // high phase of four mclk keeps the bus period at 400 ns
    q();
    @(posedge mclk);
    #5;
  endtask

  task automatic bit_out(input logic b);
    sdaPull = ~b;
    q();
    rise();
    sclPull = 1'b1;
    q();
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    // one extra pulse for the answer, data released
    sdaPull = 1'b0;
    q();
    rise();
    ackSeen = ~sda;
    ackStrobe = 1'b1;
    sclPull = 1'b1;
    @(posedge mclk);
    #5;
    ackStrobe = 1'b0;
    q();
  endtask

  // start from a released bus or a clock held low, also serves a repeated start
  task automatic start();
    sdaPull = 1'b0;
    q();
    rise();
    sdaPull = 1'b1;
    q();
    q();
    sclPull = 1'b1;
    q();
  endtask

  task automatic stop();
    sdaPull = 1'b1;
    q();
    rise();
    sdaPull = 1'b0;
    q();
    q();
  endtask
endmodule

// ===== bench/ldr_i2c_slave_tb.sv
// ldr_i2c_slave_tb.sv - self-checking bench of the display driver slave
// assumes ldr_host_model as bus master and pull-ups on both lines
`timescale 1ns/1ns
module ldr_i2c_slave_tb;
  localparam int         TICK = 10;
  localparam logic [1:0] MODES [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic        mclk;
  logic        reset;
  logic        oscSel;
  logic        extClk;
  logic        extRun;
  logic        addrLsb;
  logic [2:0]  sub;
  logic        sclOut;
  logic        sclOe;
  logic        sdaOut;
  logic        sdaOe;
  logic [3:0]  bp;
  logic [23:0] seg;
  logic        sclPull;
  logic        sdaPull;
  logic        ackStrobe;
  logic        ackSeen;
  logic        hung;
  wire         scl = !(sclOe | sclPull);
  wire         sda = !(sdaOe | sdaPull);
  logic [3:0]  expRam [24];
  logic        expAck [$];
  logic [1:0]  curMode;
  logic        dispOn;
  logic        dispOff;
  logic [31:0] rs;
  int          ptr;
  int          subCnt;
  int          cyc;
  int          nFail;
  int          totalChecks;

  ldr_i2c_slave #(.TICK_CYC(TICK), .FIFO_DEPTH(4)) dut (
    .mclk(mclk), .reset(reset),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .slaveAddrLsbStrap(addrLsb), .hwSubaddrStrapBit0(sub[0]),
    .hwSubaddrStrapBit1(sub[1]), .hwSubaddrStrapBit2(sub[2]),
    .oscillatorSelectStrap(oscSel), .extClk(extClk),
    .backplaneOut0(bp[0]), .backplaneOut1(bp[1]),
    .backplaneOut2(bp[2]), .backplaneOut3(bp[3]), .segmentOutputs(seg)
  );

  ldr_host_model host (
    .mclk(mclk), .scl(scl), .sda(sda), .sclPull(sclPull), .sdaPull(sdaPull),
    .ackStrobe(ackStrobe), .ackSeen(ackSeen), .hung(hung)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // bits per word, and backplanes in use, of a drive mode
  function automatic int wid(input logic [1:0] m);
    return (m == 2'h0) ? 4 : int'(m);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic e);
    expAck.push_back(e);
    host.send_byte(b);
  endtask

  // model store first, since the design lags only inside the quiet gap
  task automatic data(input logic [7:0] b);
    int w;
    w = wid(curMode);
    if (subCnt == int'(sub)) begin
      for (int k = 0; k < 8; k++) begin
        if (ptr + k / w < 24) expRam[ptr + k / w][k % w] = b[7 - k];
      end
    end
    put(b, subCnt == int'(sub));
    ptr += (w == 3) ? 3 : 8 / w;
    if (ptr >= 24) begin
      ptr -= 24;
      subCnt = (subCnt + 1) % 8;
    end
  endtask

  task automatic session(input logic [1:0] m, input logic lp, input logic [2:0] dev,
                         input int p, input int n);
    curMode = m;
    ptr = p;
    subCnt = int'(dev);
    host.start();
    put({6'h1F, addrLsb, 1'b0}, 1'b1);
    put({3'b110, lp, 1'b1, 1'b0, m}, 1'b1);
    put({5'b11100, dev}, 1'b1);
    put({3'b000, 5'(p)}, 1'b1);
    for (int i = 0; i < n; i++) begin
      rs = xs(rs);
      data(rs[7:0]);
    end
    host.stop();
  endtask

  // let queued words land, then open a compare window
  task automatic show();
    repeat (80) @(posedge mclk);
    #5;
    dispOn = 1'b1;
    repeat (80) @(posedge mclk);
    #5;
    dispOn = 1'b0;
  endtask

  // ----------------------------------------
  // clocks and watchers
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // external timebase, 400 ns period, moved just after an edge, stopped until asked
  initial begin
    extClk = 1'b0;
    forever begin
      repeat (4) @(posedge mclk);
      #5;
      if (extRun === 1'b1) extClk = ~extClk;
    end
  end

  // each answer slot takes the oldest note off the queue
  always @(posedge mclk) begin
    if (ackStrobe === 1'b1) begin
      if (expAck.size() == 0) begin
        check("ack slot count", 32'h1, 32'h0);
      end else begin
        check("ack", 32'(ackSeen), 32'(expAck.pop_front()));
      end
    end
  end

  // driven column against model column while a window is open
  always @(posedge mclk) begin
    int hit;
    logic [23:0] col;
    hit = -1;
    for (int p = 0; p < 4; p++) begin
      if (bp === 4'(1 << p) && p < wid(curMode)) hit = p;
    end
    for (int s = 0; s < 24; s++) col[s] = expRam[s][(hit < 0) ? 0 : hit];
    if (dispOn) begin
      check("backplane phase", 32'(hit >= 0), 32'h1);
      check("segments", 32'(seg), 32'(col));
    end
    if (dispOff) check("dark outputs", 32'({bp, seg}), 32'h0);
  end

  // cut a hang short well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      nFail++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    extRun = 1'b0;
    dispOn = 1'b0;
    dispOff = 1'b0;
    curMode = 2'h0;
    for (int s = 0; s < 24; s++) expRam[s] = 4'h0;
    rs = xs(32'hE05F8E98);
    sub = rs[2:0];
    addrLsb = rs[3];
    oscSel = 1'b0;
    repeat (2) @(posedge mclk);
    #5;
    reset = 1'b0;
    check("reset outputs", 32'({sdaOe, sclOe, bp, seg}), 32'h0);
    check("pull values", 32'({sdaOut, sclOut}), 32'h0);
    repeat (4) @(posedge mclk);
    // other strap address, then a read request: both ignored to stop
    for (int i = 0; i < 2; i++) begin
      host.start();
      put((i == 0) ? {6'h1F, ~addrLsb, 1'b0} : {6'h1F, addrLsb, 1'b1}, 1'b0);
      put(8'hC8, 1'b0);
      host.stop();
    end
    // every drive mode, last byte spills past the subaddress boundary
    for (int i = 0; i < 4; i++) begin
      session(MODES[i], 1'b0, sub, 0, 24 / ((wid(MODES[i]) == 3) ? 3 : 8 / wid(MODES[i])) + 1);
      show();
    end
    // foreign subaddress at the top word, own one after the wrap
    session(2'h0, 1'b0, sub - 3'h1, 22, 2);
    show();
    // power saving on external ticks held still, store must back up
    oscSel = 1'b1;
    fork
      session(2'h0, 1'b1, sub, 4, 10);
      begin
        for (int n = 0; n < 4000 && sclOe !== 1'b1; n++) @(posedge mclk);
        check("clock held low", 32'(sclOe), 32'h1);
        extRun = 1'b1;
      end
    join
    show();
    // display off darkens every output
    host.start();
    put({6'h1F, addrLsb, 1'b0}, 1'b1);
    put(8'h40, 1'b1);
    host.stop();
    repeat (40) @(posedge mclk);
    #5;
    dispOff = 1'b1;
    repeat (20) @(posedge mclk);
    #5;
    dispOff = 1'b0;
    check("pending acks", 32'(expAck.size()), 32'h0);
    check("host stalled", 32'(hung), 32'h0);
    print_verdict();
  end
endmodule

// ===== rtl/ldr_cfg.svh
// ldr_cfg.svh - constants of the display driver two-wire slave
// assumes inclusion by bare name from the design files
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH

// -----------------------------------------------------------------
// slave address and command fields
// -----------------------------------------------------------------
`define LDR_ADDR_HI    6'h1F
`define LDR_CONT_BIT   7
`define LDR_LP_BIT     4
`define LDR_EN_BIT     3
`define LDR_OP_MODE    2'h2
`define LDR_OP_PTR     2'h0
`define LDR_OP_DEV     3'h6

// -----------------------------------------------------------------
// drive mode codes and RAM size
// -----------------------------------------------------------------
`define LDR_M_STATIC   2'h1
`define LDR_M_DUP      2'h2
`define LDR_M_TRI      2'h3
`define LDR_M_QUAD     2'h0
`define LDR_WORDS      6'h18
`define LDR_ENTRY_W    15
`define LDR_FIFO_DEPTH 4

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define LDR_MCLK_NS    50
`define LDR_TICK_NS    5000
`define LDR_TICK_CYC   ((`LDR_TICK_NS + `LDR_MCLK_NS - 1) / `LDR_MCLK_NS)

`endif

// ===== rtl/ldr_fifo.sv
// ldr_fifo.sv - small first-in first-out store between bus and RAM
// assumes a single clock and a depth that is a power of two
`timescale 1ns/1ns
module ldr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // system
  input  wire logic             mclk,
  input  wire logic             reset,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } ldr_fifo_type;

  ldr_fifo_type q;
  ldr_fifo_type next_q;

  // full when the pointers differ only in the wrap bit
  assign inReady  = (q.wp ^ q.rp) != {1'b1, {AW{1'b0}}};
  assign outValid = q.wp != q.rp;
  assign outData  = q.mem[q.rp[AW-1:0]];

  // pointer and storage update
  always_comb begin
    next_q = q;
    if (inValid && inReady) begin
      next_q.mem[q.wp[AW-1:0]] = inData;
      next_q.wp = q.wp + 1'b1;
    end
    if (outValid && outReady) begin
      next_q.rp = q.rp + 1'b1;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule

// ===== rtl/ldr_i2c_slave.sv
// ldr_i2c_slave.sv - write-only two-wire slave with display RAM and drive
// assumes pads resolve open-drain lines from the enables; pins are async
//
// Summary of operation
// - display held in 24 by 4 RAM
// - stored one lights segment, zero darkens
// - word per segment, bit per backplane
// - bits 0 to 3 multiplexed with backplanes
// - static: byte into bit 0, eight words
// - duplex: byte into bits 0-1, four words
// - triplex: three words, last bit 2 untouched
// - quad: byte into bits 0-3, two words
// - data edges with clock high: start, stop
// - any byte count; address hit, commands and own data bytes acknowledged
// - acknowledge holds data low through pulse
// - receive only; drives acknowledges and clock holds, nothing else
// - selection: address, commands and subaddress strap
// - subaddress straps read as binary value
// - hold clock low while store is full
// - answer address 011111 plus strap bit
// - four backplanes, 24 segments, 96 elements
// - oscillator strap low selects internal timer
// - wrong address ignored until the next start or stop
// - clear top bit ends commands, data follows
// - pointer advances per byte, subaddress when the pointer wraps past 24 words
// - only matching subaddress acknowledges and stores
`timescale 1ns/1ns
`include "ldr_cfg.svh"
module ldr_i2c_slave #(
  parameter int TICK_CYC   = `LDR_TICK_CYC,
  parameter int FIFO_DEPTH = `LDR_FIFO_DEPTH
) (
  // system
  input  wire logic        mclk,
  input  wire logic        reset,
  // two-wire bus
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // straps and external timing
  input  wire logic        slaveAddrLsbStrap,
  input  wire logic        hwSubaddrStrapBit0,
  input  wire logic        hwSubaddrStrapBit1,
  input  wire logic        hwSubaddrStrapBit2,
  input  wire logic        oscillatorSelectStrap,
  input  wire logic        extClk,
  // display drive
  output logic             backplaneOut0,
  output logic             backplaneOut1,
  output logic             backplaneOut2,
  output logic             backplaneOut3,
  output logic [23:0]      segmentOutputs
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  localparam int I_SCL = 0;
  localparam int I_SDA = 1;
  localparam int I_SA0 = 2;
  localparam int I_OSC = 6;
  localparam int I_EXT = 7;

  typedef struct packed {
    logic [7:0]            s1;
    logic [7:0]            s2;
    logic [7:0]            s3;
    logic [7:0]            filt;
    ldr_pkg::ldr_link_type st;
    logic [3:0]            cnt;
    logic [7:0]            sh;
    logic                  sdaOe;
    logic                  sclOe;
    logic [1:0]            mode;
    logic                  lowPower;
    logic                  dispOn;
    logic [4:0]            ptr;
    logic [2:0]            subCnt;
    logic [7:0]            divCnt;
    logic                  tick;
    logic [1:0]            phase;
    logic [23:0][3:0]      ram;
    logic [3:0]            bp;
    logic [23:0]           seg;
  } ldr_state_type;

  ldr_state_type q;
  ldr_state_type next_q;

  logic                    sclRise;
  logic                    sclFall;
  logic                    startCond;
  logic                    stopCond;
  logic                    extRise;
  logic                    byteDue;
  logic                    addrHit;
  logic                    mine;
  logic                    push;
  logic                    fifoInReady;
  logic                    fifoOutValid;
  logic                    popNow;
  logic [`LDR_ENTRY_W-1:0] entry;
  logic [1:0]              eMode;
  logic [4:0]              ePtr;
  logic [7:0]              eData;
  logic [2:0]              subStrap;
  logic [5:0]              sum;
  logic [5:0]              wa;
  logic [5:0]              ww;
  logic [1:0]              wp;

  // highest backplane index in use for a drive mode
  function automatic logic [1:0] bpTop(input logic [1:0] m);
    unique case (m)
      `LDR_M_STATIC: return 2'h0;
      `LDR_M_DUP:    return 2'h1;
      `LDR_M_TRI:    return 2'h2;
      `LDR_M_QUAD:   return 2'h3;
    endcase
  endfunction

  // RAM words consumed by one display byte
  function automatic logic [3:0] stepOf(input logic [1:0] m);
    unique case (m)
      `LDR_M_STATIC: return 4'h8;
      `LDR_M_DUP:    return 4'h4;
      `LDR_M_TRI:    return 4'h3;
      `LDR_M_QUAD:   return 4'h2;
    endcase
  endfunction

  assign eMode    = entry[14:13];
  assign ePtr     = entry[12:8];
  assign eData    = entry[7:0];
  assign subStrap = q.filt[5:3];
  // power saving slows the RAM writer to the display tick
  assign popNow   = fifoOutValid && (!q.lowPower || q.tick);

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_q = q;
    push = 1'b0;
    sum = 6'h00;
    wa = 6'h00;
    ww = 6'h00;
    wp = 2'h0;
    // three stages; a level counts once stages two and three agree
    next_q.s1 = {extClk, oscillatorSelectStrap, hwSubaddrStrapBit2,
                 hwSubaddrStrapBit1, hwSubaddrStrapBit0, slaveAddrLsbStrap,
                 sdaIn, sclIn};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < 8; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.filt[i] = q.s3[i];
      end
    end
    sclRise = next_q.filt[I_SCL] && !q.filt[I_SCL];
    sclFall = !next_q.filt[I_SCL] && q.filt[I_SCL];
    extRise = next_q.filt[I_EXT] && !q.filt[I_EXT];
    // data edge while clock stays high
    startCond = q.filt[I_SDA] && !next_q.filt[I_SDA]
                && q.filt[I_SCL] && next_q.filt[I_SCL];
    stopCond = !q.filt[I_SDA] && next_q.filt[I_SDA]
               && q.filt[I_SCL] && next_q.filt[I_SCL];
    // write bit must be low; a read request is not answered
    addrHit = q.sh == {`LDR_ADDR_HI, q.filt[I_SA0], 1'b0};
    mine = q.subCnt == subStrap;
    byteDue = (sclFall && q.cnt == 4'h8) || q.sclOe;

    // display timebase: internal divider or external clock edges
    next_q.tick = 1'b0;
    if (!q.filt[I_OSC]) begin
      next_q.tick = q.divCnt == 8'(TICK_CYC - 1);
      next_q.divCnt = next_q.tick ? 8'h00 : q.divCnt + 8'h01;
    end else begin
      next_q.tick = extRise;
    end

    // bus receiver
    if (startCond) begin
      next_q.st = ldr_pkg::LDR_ADDR;
      next_q.cnt = 4'h0;
      next_q.sdaOe = 1'b0;
      next_q.sclOe = 1'b0;
    end else if (stopCond) begin
      next_q.st = ldr_pkg::LDR_IDLE;
      next_q.cnt = 4'h0;
      next_q.sdaOe = 1'b0;
      next_q.sclOe = 1'b0;
    end else if (q.st != ldr_pkg::LDR_IDLE && q.st != ldr_pkg::LDR_IGNORE) begin
      if (sclRise && q.cnt < 4'h8) begin
        next_q.sh = {q.sh[6:0], next_q.filt[I_SDA]};
        next_q.cnt = q.cnt + 4'h1;
      end else if (sclFall && q.cnt == 4'h9) begin
        // acknowledge pulse over: release the line
        next_q.sdaOe = 1'b0;
        next_q.cnt = 4'h0;
      end else if (byteDue) begin
        next_q.cnt = 4'h9;
        unique case (q.st)
          ldr_pkg::LDR_ADDR: begin
            if (addrHit) begin
              next_q.sdaOe = 1'b1;
              next_q.st = ldr_pkg::LDR_CMD;
            end else begin
              next_q.st = ldr_pkg::LDR_IGNORE;
            end
          end
          ldr_pkg::LDR_CMD: begin
            next_q.sdaOe = 1'b1;
            if (!q.sh[`LDR_CONT_BIT]) begin
              next_q.st = ldr_pkg::LDR_DATA;
            end
            if (q.sh[6:5] == `LDR_OP_MODE) begin
              next_q.lowPower = q.sh[`LDR_LP_BIT];
              next_q.dispOn = q.sh[`LDR_EN_BIT];
              next_q.mode = q.sh[1:0];
            end else if (q.sh[6:5] == `LDR_OP_PTR) begin
              next_q.ptr = q.sh[4:0];
            end else if (q.sh[6:4] == `LDR_OP_DEV) begin
              next_q.subCnt = q.sh[2:0];
            end
          end
          ldr_pkg::LDR_DATA: begin
            if (mine && !fifoInReady) begin
              // no room: hold the clock low, nothing is dropped
              next_q.sclOe = 1'b1;
              next_q.cnt = q.cnt;
            end else begin
              next_q.sclOe = 1'b0;
              next_q.sdaOe = mine;
              push = mine;
              // every device tracks the pointer so boundaries line up
              sum = {1'b0, q.ptr} + {2'b00, stepOf(q.mode)};
              if (sum >= `LDR_WORDS) begin
                next_q.ptr = 5'(sum - `LDR_WORDS);
                next_q.subCnt = q.subCnt + 3'h1;
              end else begin
                next_q.ptr = sum[4:0];
              end
            end
          end
          default: begin
            next_q.st = ldr_pkg::LDR_IDLE;
          end
        endcase
      end
    end

    // RAM writer: scatter a byte, most significant bit first
    if (popNow) begin
      for (int b = 0; b < 8; b++) begin
        wa = {1'b0, ePtr} + ww;
        // words past the end belong to the next device
        if (wa < `LDR_WORDS) begin
          next_q.ram[wa[4:0]][wp] = eData[7 - b];
        end
        if (wp == bpTop(eMode)) begin
          wp = 2'h0;
          ww = ww + 6'h01;
        end else begin
          wp = wp + 2'h1;
        end
      end
    end

    // display drive: one backplane per tick, segments from that bit
    if (q.tick) begin
      next_q.phase = (q.phase >= bpTop(q.mode)) ? 2'h0 : q.phase + 2'h1;
      for (int s = 0; s < 24; s++) begin
        next_q.seg[s] = q.ram[s][next_q.phase] && q.dispOn;
      end
      next_q.bp = q.dispOn ? 4'h1 << next_q.phase : 4'h0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // store between receiver and RAM writer
  ldr_fifo #(
    .WIDTH (`LDR_ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .mclk     (mclk),
    .reset    (reset),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   ({q.mode, q.ptr, q.sh}),
    .outValid (fifoOutValid),
    .outReady (popNow),
    .outData  (entry)
  );

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // open drain: only ever pull low
  assign sdaOut         = 1'b0;
  assign sclOut         = 1'b0;
  assign sdaOe          = q.sdaOe;
  assign sclOe          = q.sclOe;
  assign backplaneOut0  = q.bp[0];
  assign backplaneOut1  = q.bp[1];
  assign backplaneOut2  = q.bp[2];
  assign backplaneOut3  = q.bp[3];
  assign segmentOutputs = q.seg;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_ack_only_drive: assert property (
    q.sdaOe |-> q.cnt == 4'h9 && (q.st == ldr_pkg::LDR_CMD || q.st == ldr_pkg::LDR_DATA)
  ) else $error("data line driven outside acknowledge");

  chk_ack_held_high: assert property (
    q.sdaOe && q.filt[I_SCL] && !sclFall |=> q.sdaOe
  ) else $error("acknowledge released while clock high");

  chk_start_to_addr: assert property (
    startCond |=> q.st == ldr_pkg::LDR_ADDR && q.cnt == 4'h0 && !q.sdaOe
  ) else $error("start not taken");

  chk_stop_releases: assert property (
    stopCond |=> q.st == ldr_pkg::LDR_IDLE && !q.sdaOe && !q.sclOe
  ) else $error("stop did not release bus");

  chk_addr_miss_ignore: assert property (
    byteDue && q.st == ldr_pkg::LDR_ADDR && !addrHit && !startCond && !stopCond
    |=> q.st == ldr_pkg::LDR_IGNORE && !q.sdaOe
  ) else $error("foreign address not ignored");

  chk_cmd_end_data: assert property (
    byteDue && q.st == ldr_pkg::LDR_CMD && !q.sh[7] && !startCond && !stopCond
    |=> q.st == ldr_pkg::LDR_DATA && q.sdaOe
  ) else $error("last command did not switch to data");

  chk_stretch_hold: assert property (
    q.sclOe |-> q.st == ldr_pkg::LDR_DATA && q.cnt == 4'h8 && mine
  ) else $error("clock held without pending byte");

  chk_stretch_free: assert property (
    q.sclOe && fifoInReady && !startCond && !stopCond |=> !q.sclOe && q.sdaOe
  ) else $error("clock not released once room appeared");

  chk_store_mine: assert property (
    push |-> q.subCnt == subStrap && q.st == ldr_pkg::LDR_DATA
  ) else $error("byte stored for another subaddress");

  chk_ptr_step: assert property (
    byteDue && q.st == ldr_pkg::LDR_DATA && !q.sclOe && q.ptr < 5'h08 && !(mine && !fifoInReady)
    && !startCond && !stopCond |=> q.ptr == $past(q.ptr) + 5'(stepOf($past(q.mode)))
  ) else $error("data pointer did not advance");

  chk_static_store: assert property (
    popNow && eMode == `LDR_M_STATIC && ePtr < 5'h10
    |=> q.ram[$past(ePtr)][0] == $past(eData[7]) && q.ram[$past(ePtr) + 5'h07][0] == $past(eData[0])
  ) else $error("static byte not scattered to bit 0");

  // phase range follows the mode seen at the tick, a mode set may land with it
  chk_bp_select: assert property (
    q.tick && q.dispOn |=> q.bp[q.phase] && $onehot(q.bp) && q.phase <= bpTop($past(q.mode))
  ) else $error("backplane select wrong");

  cov_addressed: cover property (startCond ##[1:1000] q.st == ldr_pkg::LDR_CMD);
  cov_data_stored: cover property (push ##[1:300] popNow);
  cov_clock_held: cover property (q.sclOe ##1 !q.sclOe);
  cov_low_power: cover property (popNow && q.lowPower);
endmodule

// ===== rtl/ldr_pkg.sv
// ldr_pkg.sv - types of the display driver two-wire slave
// assumes nothing beyond a SystemVerilog compiler
package ldr_pkg;
  // bus receiver states
  typedef enum logic [2:0] {
    LDR_IDLE   = 3'h0,
    LDR_ADDR   = 3'h1,
    LDR_CMD    = 3'h2,
    LDR_DATA   = 3'h3,
    LDR_IGNORE = 3'h4
  } ldr_link_type;
endpackage
